// File: common/dmac_pkg.sv
package dmac_pkg;

  localparam int DMAC_DATA_W = 16;
  localparam int DMAC_MUL_W = 17;
  localparam int DMAC_PROD_W = 34;
  localparam int DMAC_MOUT_W = 33;
  localparam int DMAC_ACC_W = 40;
  localparam int DMAC_GUARD_LO = 32;
  localparam int DMAC_CLIP_BIT = 31;
  localparam int DMAC_SHIFT_W = 5;
  localparam int DMAC_BYTE_W = 8;
  localparam int DMAC_NUM_ACC = 2;

  // register byte offsets
  localparam logic [7:0] DMAC_OFF_CTRL = 8'h00;
  localparam logic [7:0] DMAC_OFF_TRAPEN = 8'h04;
  localparam logic [7:0] DMAC_OFF_OPA = 8'h08;
  localparam logic [7:0] DMAC_OFF_OPB = 8'h0C;
  localparam logic [7:0] DMAC_OFF_CMD = 8'h10;
  localparam logic [7:0] DMAC_OFF_STATUS = 8'h14;
  localparam logic [7:0] DMAC_OFF_PROD = 8'h18;
  localparam logic [7:0] DMAC_OFF_ACC1_LO = 8'h1C;
  localparam logic [7:0] DMAC_OFF_ACC1_HI = 8'h20;
  localparam logic [7:0] DMAC_OFF_ACC2_LO = 8'h24;
  localparam logic [7:0] DMAC_OFF_ACC2_HI = 8'h28;

  // core control register fields
  localparam int DMAC_CTRL_FRAC_BIT = 0;
  localparam int DMAC_CTRL_WIDTH_BIT = 4;
  localparam int DMAC_CTRL_CLIP2_BIT = 6;
  localparam int DMAC_CTRL_CLIP1_BIT = 7;
  localparam logic [7:0] DMAC_CTRL_RESET = 8'h01;
  localparam logic [7:0] DMAC_CTRL_MASK = 8'hD1;

  // trap enable register fields
  localparam int DMAC_TRAPEN_W = 2;

  // saturation targets
  localparam logic [39:0] DMAC_SAT31_POS = 40'h00_7FFF_FFFF;
  localparam logic [39:0] DMAC_SAT31_NEG = 40'hFF_8000_0000;
  localparam logic [39:0] DMAC_SAT39_POS = 40'h7F_FFFF_FFFF;
  localparam logic [39:0] DMAC_SAT39_NEG = 40'h80_0000_0000;

  typedef enum logic [2:0] {
    DMAC_OP_NOP = 3'h0,
    DMAC_OP_MAC = 3'h1,
    DMAC_OP_MSC = 3'h2,
    DMAC_OP_MPY = 3'h3,
    DMAC_OP_ADD = 3'h4,
    DMAC_OP_SUB = 3'h5,
    DMAC_OP_LAC = 3'h6,
    DMAC_OP_MUL = 3'h7
  } dmac_op_t;

  // command word, low 16 bits of a write to the command register
  typedef struct packed {
    logic [2:0] rsv_hi;
    logic [4:0] shift;
    logic rsv_lo;
    logic byte_mode;
    logic b_signed;
    logic a_signed;
    logic acc_sel;
    dmac_op_t op;
  } dmac_cmd_t;

  // status register, low 8 bits
  typedef struct packed {
    logic [1:0] sign_lost;
    logic any_clipped_flag;
    logic any_guard_overflow_flag;
    logic [1:0] clipped;
    logic [1:0] guard_ovf;
  } dmac_status_t;

endpackage

// File: design/dmac_unit.sv
// How it works
// - 17x17 multiplier runs signed or unsigned per operand, chosen by the command.
// - scaler gives 1.31 fractional product or plain 32-bit integer product.
// - unsigned operand gets zero in its extra 17th input bit.
// - signed operand copies its sign bit into the extra 17th input bit.
// - 33-bit multiplier/scaler output is sign-extended to 40 bits for accumulation.
// - fractional mode treats operands as Q15; 16x16 gives a 1.31 product.
// - same multiplier serves integer multiply, signed, unsigned and mixed sign.
// - integer product gives 16-bit result for bytes, 32-bit result for words.
// - 40-bit adder/subtractor uses selected accumulator as source and destination.
// - add and load accumulator data pass through a barrel shifter first.
// - one adder input can be forced to zero; other is true or complemented.
// - add uses true data and carry in low; subtract complements with carry in high.
// - overflow out of bit 39 is flagged as catastrophic sign loss.
// - guard overflow flagged when bits 32 to 39 are not all equal or on overflow out of bit 39.
// - overflow and clip status bits are latched and readable in the status register.
// - clipping decided from sum, overflow, clip enables at 7:6 and width bit 4.
// - clipped flag set on saturation after bit 31 or bit 39 overflow.
// - combined flags are the OR of both guard flags and both clipped flags.
// - each guard flag is rewritten by every adder operation on its own accumulator.
// - arithmetic trap raised when a guard flag and its trap enable are both set.
// - 16-bit fraction 0x8000 is -1.0 and 0x7FFF is just below one.
module dmac_unit
  import dmac_pkg::*;
#(
  parameter int DATA_W = DMAC_DATA_W,
  parameter int ACC_W = DMAC_ACC_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic arith_trap
);

  generate
    if (DATA_W != DMAC_DATA_W || ACC_W != DMAC_ACC_W) begin : g_bad_width
      $error("dmac_unit supports only 16-bit operands and 40-bit accumulators");
    end
  endgenerate

  // bus address phase capture
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  logic [7:0] ctrl_reg;
  logic [DMAC_TRAPEN_W-1:0] trapen_reg;
  logic [DATA_W-1:0] opa_reg;
  logic [DATA_W-1:0] opb_reg;
  logic [31:0] prod_reg;
  logic [ACC_W-1:0] acc_reg [DMAC_NUM_ACC];
  logic [1:0] guard_reg;
  logic [1:0] clip_reg;
  logic [1:0] lost_reg;

  wire logic addr_valid = hsel & htrans[1] & hready;
  wire logic wr_ctrl = wr_pend_reg & (addr_reg == DMAC_OFF_CTRL);
  wire logic wr_trapen = wr_pend_reg & (addr_reg == DMAC_OFF_TRAPEN);
  wire logic wr_opa = wr_pend_reg & (addr_reg == DMAC_OFF_OPA);
  wire logic wr_opb = wr_pend_reg & (addr_reg == DMAC_OFF_OPB);
  wire logic wr_cmd = wr_pend_reg & (addr_reg == DMAC_OFF_CMD);
  wire logic wr_stat = wr_pend_reg & (addr_reg == DMAC_OFF_STATUS);

  // command decode
  wire dmac_cmd_t cmd = dmac_cmd_t'(hwdata[DATA_W-1:0]);
  wire logic sel = cmd.acc_sel;
  wire logic is_mac = (cmd.op == DMAC_OP_MAC) | (cmd.op == DMAC_OP_MSC) | (cmd.op == DMAC_OP_MPY);
  wire logic is_dat = (cmd.op == DMAC_OP_ADD) | (cmd.op == DMAC_OP_SUB) | (cmd.op == DMAC_OP_LAC);
  wire logic is_sub = (cmd.op == DMAC_OP_MSC) | (cmd.op == DMAC_OP_SUB);
  wire logic zero_x = (cmd.op == DMAC_OP_MPY) | (cmd.op == DMAC_OP_LAC);
  wire logic is_mul = cmd.op == DMAC_OP_MUL;
  wire logic do_acc = wr_cmd & (is_mac | is_dat);
  wire logic do_mul = wr_cmd & is_mul;

  // operand narrowing for byte-sized integer products
  wire logic byte_sel = is_mul & cmd.byte_mode;
  wire logic [DATA_W-1:0] a_w = byte_sel ? {{DMAC_BYTE_W{cmd.a_signed & opa_reg[DMAC_BYTE_W-1]}},
    opa_reg[DMAC_BYTE_W-1:0]} : opa_reg;
  wire logic [DATA_W-1:0] b_w = byte_sel ? {{DMAC_BYTE_W{cmd.b_signed & opb_reg[DMAC_BYTE_W-1]}},
    opb_reg[DMAC_BYTE_W-1:0]} : opb_reg;

  // 17th input bit: zero when unsigned, sign copy when signed
  wire logic [DMAC_MUL_W-1:0] a17 = {cmd.a_signed & a_w[DATA_W-1], a_w};
  wire logic [DMAC_MUL_W-1:0] b17 = {cmd.b_signed & b_w[DATA_W-1], b_w};

  // one signed 17x17 multiplier for every mode and for integer products
  wire logic signed [DMAC_PROD_W-1:0] prod = $signed(a17) * $signed(b17);

  // scaler: fractional shifts left once so Q15 x Q15 lands as 1.31
  wire logic frac_mode = ctrl_reg[DMAC_CTRL_FRAC_BIT];
  wire logic [DMAC_MOUT_W-1:0] mout = frac_mode ? {prod[DMAC_MOUT_W-2:0], 1'b0}
    : prod[DMAC_MOUT_W-1:0];
  wire logic [ACC_W-1:0] mout40 = {{(ACC_W-DMAC_MOUT_W){mout[DMAC_MOUT_W-1]}}, mout};

  // integer product result width follows operand size
  wire logic [31:0] mul_res = cmd.byte_mode ? {16'h0000, prod[DATA_W-1:0]} : prod[31:0];

  // barrel shifter: data sits in bits 31:16, positive shift right, negative left
  wire logic [ACC_W-1:0] dat40 = {{(ACC_W-32){opa_reg[DATA_W-1]}}, opa_reg, 16'h0000};
  wire logic signed [DMAC_SHIFT_W-1:0] sh = $signed(cmd.shift);
  wire logic [DMAC_SHIFT_W-1:0] sh_mag = sh[DMAC_SHIFT_W-1] ? DMAC_SHIFT_W'(-sh) : cmd.shift;
  wire logic [ACC_W-1:0] dat_sh = sh[DMAC_SHIFT_W-1] ? (dat40 << sh_mag)
    : ACC_W'($signed(dat40) >>> sh_mag);

  // adder inputs
  wire logic [ACC_W-1:0] x_in = zero_x ? '0 : acc_reg[sel];
  wire logic [ACC_W-1:0] y_raw = is_mac ? mout40 : dat_sh;
  wire logic [ACC_W-1:0] y_in = is_sub ? ~y_raw : y_raw;
  wire logic carry_in = is_sub;
  wire logic [ACC_W-1:0] sum = x_in + y_in + ACC_W'(carry_in);

  // overflow detection
  wire logic cat_ovf = (x_in[ACC_W-1] == y_in[ACC_W-1]) & (sum[ACC_W-1] != x_in[ACC_W-1]);
  wire logic guard_ovf = ~(&sum[ACC_W-1:DMAC_GUARD_LO] | ~|sum[ACC_W-1:DMAC_GUARD_LO]);
  wire logic b31_ovf = ~(&sum[ACC_W-1:DMAC_CLIP_BIT] | ~|sum[ACC_W-1:DMAC_CLIP_BIT]);
  wire logic true_neg = cat_ovf ? ~sum[ACC_W-1] : sum[ACC_W-1];

  // saturation control
  wire logic wide_clip = ctrl_reg[DMAC_CTRL_WIDTH_BIT];
  wire logic clip_en = sel ? ctrl_reg[DMAC_CTRL_CLIP2_BIT] : ctrl_reg[DMAC_CTRL_CLIP1_BIT];
  wire logic sat_hit = clip_en & (wide_clip ? cat_ovf : (cat_ovf | b31_ovf));
  wire logic [ACC_W-1:0] sat_val = wide_clip ? (true_neg ? DMAC_SAT39_NEG : DMAC_SAT39_POS)
    : (true_neg ? DMAC_SAT31_NEG : DMAC_SAT31_POS);
  wire logic [ACC_W-1:0] acc_new = sat_hit ? sat_val : sum;

  // status write-one-to-clear with set winning
  wire dmac_status_t stat_wr = dmac_status_t'(hwdata[7:0]);
  wire logic [1:0] hit = do_acc ? (sel ? 2'b10 : 2'b01) : 2'b00;
  wire logic [1:0] clip_clr = wr_stat ? stat_wr.clipped : 2'b00;
  wire logic [1:0] lost_clr = wr_stat ? stat_wr.sign_lost : 2'b00;
  wire logic [1:0] guard_clr = wr_stat ? stat_wr.guard_ovf : 2'b00;

  logic [1:0] guard_next;
  logic [1:0] clip_next;
  logic [1:0] lost_next;

  generate
    for (genvar i = 0; i < DMAC_NUM_ACC; i++) begin : g_flag
      assign guard_next[i] = hit[i] ? (guard_ovf | cat_ovf) : (guard_reg[i] & ~guard_clr[i]);
      assign clip_next[i] = (hit[i] & sat_hit) | (clip_reg[i] & ~clip_clr[i]);
      assign lost_next[i] = (hit[i] & cat_ovf) | (lost_reg[i] & ~lost_clr[i]);

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          acc_reg[i] <= '0;
        end else if (hit[i]) begin
          acc_reg[i] <= acc_new;
        end
      end

      // guard overflow flag, rewritten by every adder pass on this accumulator
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          guard_reg[i] <= 1'b0;
        end else begin
          guard_reg[i] <= guard_next[i];
        end
      end

      // clipped flag, set wins over clear
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          clip_reg[i] <= 1'b0;
        end else begin
          clip_reg[i] <= clip_next[i];
        end
      end

      // sign lost flag, set wins over clear
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          lost_reg[i] <= 1'b0;
        end else begin
          lost_reg[i] <= lost_next[i];
        end
      end
    end
  endgenerate

  // status view
  dmac_status_t status;
  assign status.guard_ovf = guard_reg;
  assign status.clipped = clip_reg;
  assign status.any_guard_overflow_flag = |guard_reg;
  assign status.any_clipped_flag = |clip_reg;
  assign status.sign_lost = lost_reg;

  assign arith_trap = |(guard_reg & trapen_reg);

  // bus side
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= addr_valid & hwrite;
      addr_reg <= addr_valid ? haddr[7:0] : 8'h00;
    end
  end

  // core control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= DMAC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= hwdata[7:0] & DMAC_CTRL_MASK;
    end
  end

  // trap enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trapen_reg <= '0;
    end else if (wr_trapen) begin
      trapen_reg <= hwdata[DMAC_TRAPEN_W-1:0];
    end
  end

  // first operand, also the add and load data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opa_reg <= '0;
    end else if (wr_opa) begin
      opa_reg <= hwdata[DATA_W-1:0];
    end
  end

  // second operand
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opb_reg <= '0;
    end else if (wr_opb) begin
      opb_reg <= hwdata[DATA_W-1:0];
    end
  end

  // integer product result
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prod_reg <= '0;
    end else if (do_mul) begin
      prod_reg <= mul_res;
    end
  end

  // read select, unmapped reads return zero
  wire logic rd_ctrl = addr_reg == DMAC_OFF_CTRL;
  wire logic rd_trapen = addr_reg == DMAC_OFF_TRAPEN;
  wire logic rd_opa = addr_reg == DMAC_OFF_OPA;
  wire logic rd_opb = addr_reg == DMAC_OFF_OPB;
  wire logic rd_stat = addr_reg == DMAC_OFF_STATUS;
  wire logic rd_prod = addr_reg == DMAC_OFF_PROD;
  wire logic rd_a1lo = addr_reg == DMAC_OFF_ACC1_LO;
  wire logic rd_a1hi = addr_reg == DMAC_OFF_ACC1_HI;
  wire logic rd_a2lo = addr_reg == DMAC_OFF_ACC2_LO;
  wire logic rd_a2hi = addr_reg == DMAC_OFF_ACC2_HI;

  wire logic [31:0] rd_mux = ({32{rd_ctrl}} & {24'h000000, ctrl_reg})
    | ({32{rd_trapen}} & {30'h00000000, trapen_reg})
    | ({32{rd_opa}} & {16'h0000, opa_reg})
    | ({32{rd_opb}} & {16'h0000, opb_reg})
    | ({32{rd_stat}} & {24'h000000, status})
    | ({32{rd_prod}} & prod_reg)
    | ({32{rd_a1lo}} & acc_reg[0][31:0])
    | ({32{rd_a1hi}} & {24'h000000, acc_reg[0][ACC_W-1:32]})
    | ({32{rd_a2lo}} & acc_reg[1][31:0])
    | ({32{rd_a2hi}} & {24'h000000, acc_reg[1][ACC_W-1:32]});

  assign hrdata = rd_mux;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule

// File: verif/dmac_unit_props.sv
module dmac_unit_props
  import dmac_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic arith_trap
);
  logic rd_q;
  logic wr_q;
  logic [7:0] a_q;
  // data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      a_q <= 8'h00;
    end else if (hready) begin
      rd_q <= hsel & htrans[1] & !hwrite;
      wr_q <= hsel & htrans[1] & hwrite;
      a_q <= haddr[7:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ctrl_bits; rd_q && a_q == DMAC_OFF_CTRL |-> hrdata[31:8] == 24'h0 && (hrdata[7:0] & ~DMAC_CTRL_MASK) == 8'h0;
  endproperty
  a_ctrl_bits: assert property (p_ctrl_bits) else $error("ctrl spare bits set");
  property p_or_guard; rd_q && a_q == DMAC_OFF_STATUS |-> hrdata[4] == |hrdata[1:0]; endproperty
  a_or_guard: assert property (p_or_guard) else $error("combined guard flag wrong");
  property p_or_clip; rd_q && a_q == DMAC_OFF_STATUS |-> hrdata[5] == |hrdata[3:2]; endproperty
  a_or_clip: assert property (p_or_clip) else $error("combined clip flag wrong");
  property p_trap_mask; rd_q && a_q == DMAC_OFF_STATUS && hrdata[1:0] == 2'h0 |-> !arith_trap; endproperty
  a_trap_mask: assert property (p_trap_mask) else $error("trap without guard flag");
  property p_trap_hold; !wr_q |=> $stable(arith_trap); endproperty
  a_trap_hold: assert property (p_trap_hold) else $error("trap moved without a write");
  property p_hi_ext; rd_q && (a_q == DMAC_OFF_ACC1_HI || a_q == DMAC_OFF_ACC2_HI) |-> hrdata[31:8] == 24'h0; endproperty
  a_hi_ext: assert property (p_hi_ext) else $error("acc high word too wide");
  property p_stat_hi; rd_q && a_q == DMAC_OFF_STATUS |-> hrdata[31:8] == 24'h0; endproperty
  a_stat_hi: assert property (p_stat_hi) else $error("status spare bits set");
  property p_cmd_rd; rd_q && a_q == DMAC_OFF_CMD |-> hrdata == 32'h0; endproperty
  a_cmd_rd: assert property (p_cmd_rd) else $error("command reads nonzero");
  c_clip: cover property (rd_q && a_q == DMAC_OFF_STATUS && hrdata[2]);
  c_trap: cover property (arith_trap);
  c_prod: cover property (rd_q && a_q == DMAC_OFF_PROD);
endmodule
bind dmac_unit dmac_unit_props dmac_unit_props_inst(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .arith_trap(arith_trap));

// File: verif/dmac_host.sv
module dmac_host
  import dmac_pkg::*;
(
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one single word transfer, waits for the slave on both phases
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hwdata <= ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule

// File: verif/tb_top.sv
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %0t %h %h", $time, g, e); end end
module tb_top;
  import dmac_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hready, hreadyout, hresp, arith_trap;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int error_cnt = 0;
  int compares = 0;
  always #12.5 hclk = ~hclk;
  assign hready = hreadyout;
  dmac_unit dmac_unit_inst(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .arith_trap(arith_trap));
  dmac_host dmac_host_inst(.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  task automatic give_verdict();
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    dmac_host_inst.xfer(1'b1, a, d, q);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    dmac_host_inst.xfer(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  task automatic run(input dmac_op_t op, input logic acc, input logic [15:0] a, input logic [15:0] b,
    input logic sa, input logic sb, input logic bm, input logic [4:0] sh);
    dmac_cmd_t c;
    c = {3'h0, sh, 1'b0, bm, sb, sa, acc, op};
    wr(DMAC_OFF_OPA, {16'h0, a});
    wr(DMAC_OFF_OPB, {16'h0, b});
    wr(DMAC_OFF_CMD, {16'h0, c});
  endtask
  task automatic acc_chk(input logic acc, input logic [39:0] e);
    chk(acc ? DMAC_OFF_ACC2_LO : DMAC_OFF_ACC1_LO, e[31:0]);
    chk(acc ? DMAC_OFF_ACC2_HI : DMAC_OFF_ACC1_HI, {24'h0, e[39:32]});
  endtask
  task automatic t_regs();
    chk(DMAC_OFF_CTRL, 32'h0000_0001);
    chk(DMAC_OFF_STATUS, 32'h0);
    wr(DMAC_OFF_CTRL, 32'hFFFF_FFFF);
    chk(DMAC_OFF_CTRL, 32'h0000_00D1);
    chk(DMAC_OFF_CMD, 32'h0);
    chk(8'h40, 32'h0);
  endtask
  task automatic t_mul();
    logic [31:0] ex [4] = '{32'hFFFE_0001, 32'hFFFF_0001, 32'hFFFF_0001, 32'h0000_0001};
    for (int i = 0; i < 4; i++) begin
      run(DMAC_OP_MUL, 1'b0, 16'hFFFF, 16'hFFFF, i[0], i[1], 1'b0, 5'h00);
      chk(DMAC_OFF_PROD, ex[i]);
    end
    run(DMAC_OP_MUL, 1'b0, 16'h00FF, 16'h0003, 1'b1, 1'b1, 1'b1, 5'h00);
    chk(DMAC_OFF_PROD, 32'h0000_FFFD);
    run(DMAC_OP_MUL, 1'b0, 16'h00FF, 16'h0003, 1'b0, 1'b0, 1'b1, 5'h00);
    chk(DMAC_OFF_PROD, 32'h0000_02FD);
  endtask
  task automatic t_frac();
    wr(DMAC_OFF_CTRL, 32'h0000_0001);
    run(DMAC_OP_MPY, 1'b0, 16'h8000, 16'h8000, 1'b1, 1'b1, 1'b0, 5'h00);
    acc_chk(1'b0, 40'h00_8000_0000);
    wr(DMAC_OFF_CTRL, 32'h0);
    run(DMAC_OP_MPY, 1'b0, 16'h8000, 16'h8000, 1'b1, 1'b1, 1'b0, 5'h00);
    acc_chk(1'b0, 40'h00_4000_0000);
  endtask
  task automatic t_acc();
    wr(DMAC_OFF_TRAPEN, 32'h1);
    run(DMAC_OP_LAC, 1'b0, 16'h4000, 16'h0, 1'b1, 1'b1, 1'b0, 5'h1F);
    acc_chk(1'b0, 40'h00_8000_0000);
    run(DMAC_OP_ADD, 1'b0, 16'h4000, 16'h0, 1'b1, 1'b1, 1'b0, 5'h1F);
    acc_chk(1'b0, 40'h01_0000_0000);
    chk(DMAC_OFF_STATUS, 32'h11);
    `CHK(arith_trap, 1'b1)
    run(DMAC_OP_SUB, 1'b0, 16'h4000, 16'h0, 1'b1, 1'b1, 1'b0, 5'h1F);
    chk(DMAC_OFF_STATUS, 32'h0);
    `CHK(arith_trap, 1'b0)
    wr(DMAC_OFF_CTRL, 32'h80);
    run(DMAC_OP_ADD, 1'b0, 16'h4000, 16'h0, 1'b1, 1'b1, 1'b0, 5'h1F);
    acc_chk(1'b0, 40'h00_7FFF_FFFF);
    chk(DMAC_OFF_STATUS, 32'h35);
    wr(DMAC_OFF_STATUS, 32'hFF);
    chk(DMAC_OFF_STATUS, 32'h0);
  endtask
  task automatic t_acc2();
    wr(DMAC_OFF_CTRL, 32'h0);
    run(DMAC_OP_SUB, 1'b1, 16'h0001, 16'h0, 1'b1, 1'b1, 1'b0, 5'h00);
    acc_chk(1'b1, 40'hFF_FFFF_0000);
    run(DMAC_OP_MAC, 1'b1, 16'h0002, 16'h0003, 1'b1, 1'b1, 1'b0, 5'h00);
    acc_chk(1'b1, 40'hFF_FFFF_0006);
    run(DMAC_OP_MSC, 1'b1, 16'h0002, 16'h0003, 1'b1, 1'b1, 1'b0, 5'h00);
    acc_chk(1'b1, 40'hFF_FFFF_0000);
    wr(DMAC_OFF_CTRL, 32'h50);
    run(DMAC_OP_LAC, 1'b1, 16'h7FFF, 16'h0, 1'b1, 1'b1, 1'b0, 5'h18);
    run(DMAC_OP_ADD, 1'b1, 16'h7FFF, 16'h0, 1'b1, 1'b1, 1'b0, 5'h18);
    acc_chk(1'b1, 40'h7F_FFFF_FFFF);
    chk(DMAC_OFF_STATUS, 32'hBA);
    `CHK(arith_trap, 1'b0)
    wr(DMAC_OFF_TRAPEN, 32'h3);
    @(negedge hclk);
    `CHK(arith_trap, 1'b1)
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_mul();
    t_frac();
    t_acc();
    t_acc2();
    give_verdict();
  end
  // watchdog
  initial begin
    #100us;
    error_cnt++;
    give_verdict();
  end
endmodule
